// *** core/tx_command_control_regs.svh ***
// Register offsets, field positions and reset values for the transmit command block.
// Assumes byte addressing on a 32-bit AXI4-Lite register bus.
`ifndef TX_COMMAND_CONTROL_REGS_SVH
`define TX_COMMAND_CONTROL_REGS_SVH

// ----------------------------------------
// Register offsets (index, byte = 4*index)
// ----------------------------------------
`define SYSTEM_CONTROL_INDEX 8'h0D
`define SYSTEM_CONTROL_ADDR 8'h34
`define DELAYED_TIME_LO_ADDR 8'h40
`define DELAYED_TIME_HI_ADDR 8'h44
`define FRAME_LENGTH_ADDR 8'h48
`define SYSTEM_TIME_LO_ADDR 8'h4C
`define SYSTEM_TIME_HI_ADDR 8'h50
`define TX_STATUS_ADDR 8'h54
`define ANTENNA_DELAY_ADDR 8'h58
`define TX_STAMP_LO_ADDR 8'h5C
`define TX_STAMP_HI_ADDR 8'h60

// ----------------------------------------
// Control bit positions
// ----------------------------------------
`define BIT_SUPPRESS_CHECKSUM 0
`define BIT_TRANSMIT_START 1
`define BIT_DELAYED_SEND 2
`define BIT_CANCEL_SUPPRESSION 3
`define BIT_TRANSCEIVER_OFF 6
`define BIT_WAIT_FOR_RESPONSE 7
`define BIT_RECEIVE_ENABLE 8
`define BIT_DELAYED_RECEIVE 9
`define BIT_BUFFER_POINTER_TOGGLE 24
`define SYSTEM_CONTROL_MASK 32'h010003CF
`define SYSTEM_CONTROL_RESET 32'h00000000

// ----------------------------------------
// Timing, checksum and bus response constants
// ----------------------------------------
`define TIME_WIDTH 40
`define DELAY_IGNORED_BITS 9
`define CHECKSUM_BYTES 11'h002
`define CRC_POLY 16'h1021
`define CRC_INIT 16'h0000
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

`endif

// *** core/tx_command_control_pkg.sv ***
// Types shared by the transmit command block.
// Assumes the register header is included by the users of this package.
package tx_command_control_pkg;
	typedef enum logic [1:0] {TX_IDLE, TX_WAIT_TIME, TX_SEND, TX_APPEND} tx_state_e;
endpackage : tx_command_control_pkg

// *** core/crc16_byte.sv ***
// One-byte step of a bit-reflected CRC-16 over x^16+x^12+x^5+1.
// Assumes the caller holds the running value in its own register.
`timescale 1ns/10ps
`default_nettype none
`include "tx_command_control_regs.svh"
module crc16_byte (
	// Running value
	input wire logic [15:0] crcIn,
	// Next octet
	input wire logic [7:0] dataIn,
	// Updated value
	output logic [15:0] crcOut
);
	localparam logic [15:0] POLY_REFLECTED = 16'h8408;
	logic [15:0] stage [0:8];
	assign stage[0] = crcIn;
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_bit
			logic fb;
			assign fb = stage[i][0] ^ dataIn[i];
			assign stage[i + 1] = (stage[i] >> 1) ^ (fb ? POLY_REFLECTED : 16'h0000);
		end
	endgenerate
	assign crcOut = stage[8];
endmodule : crc16_byte
`default_nettype wire

// *** core/tx_command_control.sv ***
// Transmit command logic behind the system control register, with AXI4-Lite access.
// Assumes one clock, a synchronous reset and a byte-wide buffer read port.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "tx_command_control_regs.svh"
module tx_command_control
	import tx_command_control_pkg::*;
#(
	parameter int LEN_WIDTH = 11
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Transmit buffer read port, data valid the cycle after the address
	output logic [LEN_WIDTH-1:0] bufAddr,
	input wire logic [7:0] bufData,
	// Octet stream to the radio path
	output logic [7:0] txData,
	output logic txValid,
	output logic txLast,
	input wire logic txReady,
	// Status
	output logic txBusy
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [31:0] ctrl_q, ctrl_d;
	logic [`TIME_WIDTH-1:0] dlyTime_q, dlyTime_d, sysTime_q, sysTime_d;
	logic [`TIME_WIDTH-1:0] stamp_q, stamp_d;
	logic [15:0] antDelay_q, antDelay_d;
	logic [LEN_WIDTH-1:0] frameLen_q, frameLen_d, count_q, count_d;
	tx_state_e state_q, state_d;
	logic sendFcs_q, sendFcs_d, pend_q, pend_d, lastFetch_q, lastFetch_d;
	logic [15:0] crc_q, crc_d, crcNext;
	logic [7:0] txData_q, txData_d;
	logic txValid_q, txValid_d, txLast_q, txLast_d, fcsHi_q, fcsHi_d;
	logic awHeld_q, awHeld_d, wHeld_q, wHeld_d, bValid_q, bValid_d, wrErr_q, wrErr_d;
	logic rValid_q, rValid_d, rdErr_q, rdErr_d;
	logic [7:0] awAddr_q, awAddr_d;
	logic [31:0] wData_q, wData_d, rData_q, rData_d, rdMux;
	logic [3:0] wStrb_q, wStrb_d;
	logic doWrite, rdHit;
	logic [31:0] wMerged;
	logic [LEN_WIDTH-1:0] fetchLen;

	crc16_byte u_crc (
		.crcIn(crc_q),
		.dataIn(txData_q),
		.crcOut(crcNext)
	);

	assign s_axi_awready = !awHeld_q && !bValid_q;
	assign s_axi_wready = !wHeld_q && !bValid_q;
	assign s_axi_arready = !rValid_q;
	assign s_axi_bvalid = bValid_q;
	assign s_axi_bresp = wrErr_q ? `AXI_SLVERR : `AXI_OKAY;
	assign s_axi_rvalid = rValid_q;
	assign s_axi_rdata = rData_q;
	assign s_axi_rresp = rdErr_q ? `AXI_SLVERR : `AXI_OKAY;
	assign txData = txData_q;
	assign txValid = txValid_q;
	assign txLast = txLast_q;
	assign bufAddr = count_q;
	assign txBusy = (state_q != TX_IDLE);
	assign doWrite = awHeld_q && wHeld_q && !bValid_q;
	assign fetchLen = sendFcs_q ? frameLen_q - `CHECKSUM_BYTES : frameLen_q;

	// Byte-lane merge of held write data into the addressed register
	always_comb begin
		wMerged = rdMux;
		for (int b = 0; b < 4; b++) begin
			if (wStrb_q[b]) begin
				wMerged[b*8 +: 8] = wData_q[b*8 +: 8];
			end
		end
	end

	// ----------------------------------------
	// Read decode
	// ----------------------------------------
	function automatic logic [31:0] readReg(input logic [7:0] a, output logic hit);
		hit = 1'b1;
		unique case (a)
			`SYSTEM_CONTROL_ADDR: readReg = ctrl_q;
			`DELAYED_TIME_LO_ADDR: readReg = dlyTime_q[31:0];
			`DELAYED_TIME_HI_ADDR: readReg = {24'h000000, dlyTime_q[39:32]};
			`FRAME_LENGTH_ADDR: readReg = 32'(frameLen_q);
			`SYSTEM_TIME_LO_ADDR: readReg = sysTime_q[31:0];
			`SYSTEM_TIME_HI_ADDR: readReg = {24'h000000, sysTime_q[39:32]};
			`TX_STATUS_ADDR: readReg = {30'h00000000, pend_q, txBusy};
			`ANTENNA_DELAY_ADDR: readReg = {16'h0000, antDelay_q};
			`TX_STAMP_LO_ADDR: readReg = stamp_q[31:0];
			`TX_STAMP_HI_ADDR: readReg = {24'h000000, stamp_q[39:32]};
			default: begin
				readReg = 32'h00000000;
				hit = 1'b0;
			end
		endcase
	endfunction : readReg

	always_comb begin
		logic h;
		h = 1'b0;
		rdMux = readReg(awAddr_q, h);
	end

	// ----------------------------------------
	// Bus slave next state
	// ----------------------------------------
	always_comb begin
		logic rh, wh;
		logic [31:0] rv;
		rh = 1'b0;
		wh = 1'b0;
		rv = 32'h00000000;
		awHeld_d = awHeld_q;
		wHeld_d = wHeld_q;
		awAddr_d = awAddr_q;
		wData_d = wData_q;
		wStrb_d = wStrb_q;
		bValid_d = bValid_q;
		wrErr_d = wrErr_q;
		rValid_d = rValid_q;
		rData_d = rData_q;
		rdErr_d = rdErr_q;
		if (s_axi_awvalid && s_axi_awready) begin
			awHeld_d = 1'b1;
			awAddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wHeld_d = 1'b1;
			wData_d = s_axi_wdata;
			wStrb_d = s_axi_wstrb;
		end
		if (doWrite) begin
			rv = readReg(awAddr_q, wh);
			awHeld_d = 1'b0;
			wHeld_d = 1'b0;
			bValid_d = 1'b1;
			wrErr_d = !wh;
		end else if (bValid_q && s_axi_bready) begin
			bValid_d = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rData_d = readReg(s_axi_araddr, rh);
			rValid_d = 1'b1;
			rdErr_d = !rh;
		end else if (rValid_q && s_axi_rready) begin
			rValid_d = 1'b0;
		end
	end

	// ----------------------------------------
	// Registers and transmit sequencer
	// ----------------------------------------
	always_comb begin
		logic [`TIME_WIDTH-1:0] target;
		logic startNow;
		target = {dlyTime_q[39:`DELAY_IGNORED_BITS], {`DELAY_IGNORED_BITS{1'b0}}};
		startNow = 1'b0;
		ctrl_d = ctrl_q;
		dlyTime_d = dlyTime_q;
		frameLen_d = frameLen_q;
		antDelay_d = antDelay_q;
		sysTime_d = sysTime_q + 40'h0000000001;
		stamp_d = stamp_q;
		state_d = state_q;
		sendFcs_d = sendFcs_q;
		pend_d = pend_q;
		count_d = count_q;
		lastFetch_d = lastFetch_q;
		crc_d = crc_q;
		txData_d = txData_q;
		txValid_d = txValid_q;
		txLast_d = txLast_q;
		fcsHi_d = fcsHi_q;
		if (doWrite) begin
			unique case (awAddr_q)
				`SYSTEM_CONTROL_ADDR: ctrl_d = wMerged & `SYSTEM_CONTROL_MASK;
				`DELAYED_TIME_LO_ADDR: dlyTime_d[31:0] = wMerged;
				`DELAYED_TIME_HI_ADDR: dlyTime_d[39:32] = wMerged[7:0];
				`FRAME_LENGTH_ADDR: frameLen_d = wMerged[LEN_WIDTH-1:0];
				`ANTENNA_DELAY_ADDR: antDelay_d = wMerged[15:0];
				default: ;
			endcase
		end
		// The cancel-suppression bit self-clears the cycle after it is seen, so software never sees it stuck
		ctrl_d[`BIT_CANCEL_SUPPRESSION] = ctrl_q[`BIT_CANCEL_SUPPRESSION] ? 1'b0 : ctrl_d[`BIT_CANCEL_SUPPRESSION];
		if (state_q == TX_SEND && ctrl_q[`BIT_CANCEL_SUPPRESSION]) begin
			sendFcs_d = 1'b1;
		end
		if (ctrl_q[`BIT_TRANSCEIVER_OFF]) begin
			ctrl_d[`BIT_TRANSCEIVER_OFF] = 1'b0;
			ctrl_d[`BIT_WAIT_FOR_RESPONSE] = 1'b0;
			ctrl_d[`BIT_DELAYED_SEND] = 1'b0;
			ctrl_d[`BIT_TRANSMIT_START] = 1'b0;
			ctrl_d[`BIT_SUPPRESS_CHECKSUM] = 1'b0;
			state_d = TX_IDLE;
			txValid_d = 1'b0;
			pend_d = 1'b0;
		end else begin
			unique case (state_q)
				TX_IDLE: begin
					if (ctrl_q[`BIT_TRANSMIT_START]) begin
						if (ctrl_q[`BIT_DELAYED_SEND]) begin
							state_d = TX_WAIT_TIME;
						end else begin
							startNow = 1'b1;
						end
					end
				end
				TX_WAIT_TIME: begin
					// Start and delayed-send stay set while waiting
					if (sysTime_q == target) begin
						startNow = 1'b1;
					end
				end
				TX_SEND: begin
					if (!txValid_q || txReady) begin
						txValid_d = 1'b0;
						if (pend_q) begin
							txData_d = bufData;
							txValid_d = 1'b1;
							txLast_d = lastFetch_q && !sendFcs_q;
							pend_d = 1'b0;
						end
						if (txValid_q && sendFcs_q) begin
							crc_d = crcNext;
						end
						if (!pend_q && !lastFetch_q) begin
							pend_d = 1'b1;
							lastFetch_d = (count_q == fetchLen - 11'(1));
						end else if (pend_q && !lastFetch_q) begin
							// New address needs a full cycle before its octet is read back
							count_d = count_q + LEN_WIDTH'(1);
							pend_d = 1'b0;
						end
						if (txValid_q && txLast_q) begin
							txValid_d = 1'b0;
							txLast_d = 1'b0;
							state_d = TX_IDLE;
						end else if (!pend_q && lastFetch_q && txValid_q && sendFcs_q) begin
							state_d = TX_APPEND;
							txData_d = ~crcNext[7:0];
							txValid_d = 1'b1;
							fcsHi_d = 1'b0;
						end
					end
				end
				TX_APPEND: begin
					if (txReady) begin
						if (fcsHi_q) begin
							txValid_d = 1'b0;
							txLast_d = 1'b0;
							state_d = TX_IDLE;
						end else begin
							txData_d = ~crc_q[15:8];
							txLast_d = 1'b1;
							fcsHi_d = 1'b1;
						end
					end
				end
				default: state_d = TX_IDLE;
			endcase
		end
		if (state_q == TX_APPEND && txReady && !fcsHi_q) begin
			crc_d = crcNext;
		end
		if (startNow) begin
			ctrl_d[`BIT_TRANSMIT_START] = 1'b0;
			ctrl_d[`BIT_DELAYED_SEND] = 1'b0;
			ctrl_d[`BIT_SUPPRESS_CHECKSUM] = 1'b0;
			sendFcs_d = !ctrl_q[`BIT_SUPPRESS_CHECKSUM];
			stamp_d = (state_q == TX_WAIT_TIME ? target : sysTime_q) + 40'(antDelay_q);
			state_d = TX_SEND;
			count_d = '0;
			pend_d = 1'b0;
			lastFetch_d = 1'b0;
			crc_d = `CRC_INIT;
			txValid_d = 1'b0;
			txLast_d = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ctrl_q <= `SYSTEM_CONTROL_RESET;
			dlyTime_q <= '0;
			sysTime_q <= '0;
			stamp_q <= '0;
			antDelay_q <= '0;
			frameLen_q <= '0;
			count_q <= '0;
			state_q <= TX_IDLE;
			sendFcs_q <= 1'b0;
			pend_q <= 1'b0;
			lastFetch_q <= 1'b0;
			crc_q <= `CRC_INIT;
			txData_q <= '0;
			txValid_q <= 1'b0;
			txLast_q <= 1'b0;
			fcsHi_q <= 1'b0;
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= '0;
			wData_q <= '0;
			wStrb_q <= '0;
			bValid_q <= 1'b0;
			wrErr_q <= 1'b0;
			rValid_q <= 1'b0;
			rData_q <= '0;
			rdErr_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			dlyTime_q <= dlyTime_d;
			sysTime_q <= sysTime_d;
			stamp_q <= stamp_d;
			antDelay_q <= antDelay_d;
			frameLen_q <= frameLen_d;
			count_q <= count_d;
			state_q <= state_d;
			sendFcs_q <= sendFcs_d;
			pend_q <= pend_d;
			lastFetch_q <= lastFetch_d;
			crc_q <= crc_d;
			txData_q <= txData_d;
			txValid_q <= txValid_d;
			txLast_q <= txLast_d;
			fcsHi_q <= fcsHi_d;
			awHeld_q <= awHeld_d;
			wHeld_q <= wHeld_d;
			awAddr_q <= awAddr_d;
			wData_q <= wData_d;
			wStrb_q <= wStrb_d;
			bValid_q <= bValid_d;
			wrErr_q <= wrErr_d;
			rValid_q <= rValid_d;
			rData_q <= rData_d;
			rdErr_q <= rdErr_d;
		end
	end
endmodule : tx_command_control
`default_nettype wire

// *** bench/tx_sink_model.sv ***
// Far side: synchronous transmit buffer and a stalling octet sink.
// Assumes one octet per buffer address, valid a cycle later.
`timescale 1ns/10ps
`default_nettype none
module tx_sink_model (
	// Clock
	input wire logic core_clk,
	// Buffer port
	input wire logic [10:0] bufAddr,
	output logic [7:0] bufData,
	// Octet stream
	input wire logic [7:0] txData,
	input wire logic txValid,
	input wire logic txLast,
	output logic txReady
);
	logic [7:0] rxBytes [0:63];
	int rxCount = 0;
	int frames = 0;
	logic [1:0] cnt = 2'h0;
	initial begin
		txReady = 1'b0;
		bufData = 8'h00;
	end
	always @(posedge core_clk) begin
		bufData <= 8'(bufAddr * 37 + 5);
		cnt <= cnt + 2'h1;
		// Stall one cycle in four to exercise holding
		txReady <= (cnt != 2'h2);
		if (txValid && txReady) begin
			rxBytes[rxCount] <= txData;
			rxCount <= rxCount + 1;
			if (txLast) frames <= frames + 1;
		end
	end
endmodule : tx_sink_model
`default_nettype wire

// *** bench/tx_command_control_assertions.sv ***
// Port checker for the transmit command block.
// Assumes it is bound to tx_command_control.
`timescale 1ns/10ps
`default_nettype none
`include "tx_command_control_regs.svh"
module tx_command_control_assertions (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Register bus
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rready,
	// Stream
	input wire logic [7:0] txData,
	input wire logic txValid,
	input wire logic txLast,
	input wire logic txReady,
	input wire logic txBusy
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	property p_txHold;
		txValid && !txReady |=> txValid && $stable({txData, txLast});
	endproperty
	a_txHold: assert property (p_txHold) else $error("octet changed before accept");
	property p_bHold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_bHold: assert property (p_bHold) else $error("write answer withdrawn");
	property p_rHold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rHold: assert property (p_rHold) else $error("read answer withdrawn");
	property p_arBlock;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_arBlock: assert property (p_arBlock) else $error("read taken while answer pending");
	property p_busy;
		txValid |-> txBusy;
	endproperty
	a_busy: assert property (p_busy) else $error("stream active while idle");
	property p_start;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			&& s_axi_awaddr == `SYSTEM_CONTROL_ADDR && s_axi_wdata[2:1] == 2'h1
			&& !s_axi_wdata[6] && !txBusy |-> ##[2:10] txValid;
	endproperty
	a_start: assert property (p_start) else $error("immediate send did not start");
	property p_last;
		txValid && txReady && txLast |=> !txValid;
	endproperty
	a_last: assert property (p_last) else $error("octet after frame end");
	property p_rst;
		disable iff (1'b0) sys_rst |=> !txValid && !txBusy && !s_axi_bvalid && !s_axi_rvalid;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs active after reset");
endmodule : tx_command_control_assertions
bind tx_command_control tx_command_control_assertions u_tx_command_control_assertions (
	.core_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rdata, .s_axi_rready, .txData, .txValid, .txLast, .txReady, .txBusy
);
`default_nettype wire

// *** bench/tx_command_control_tb.sv ***
// Self-checking bench for the transmit command block.
// Assumes the sink model as far side and the register header on the path.
`timescale 1ns/10ps
`default_nettype none
`include "tx_command_control_regs.svh"
module tx_command_control_tb;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, bufData, txData;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic txValid, txLast, txReady, txBusy;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [10:0] bufAddr;
	int n_errors = 0;
	int n_checks = 0;
	tx_command_control u_tx_command_control (
		.core_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .bufAddr, .bufData, .txData, .txValid, .txLast, .txReady, .txBusy
	);
	tx_sink_model u_tx_sink_model (.core_clk, .bufAddr, .bufData, .txData, .txValid, .txLast, .txReady);
	initial begin
		forever #20 core_clk = ~core_clk;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : final_report
	// ----------------------------------------
	// Register bus master
	// ----------------------------------------
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
		logic aw, w, hs;
		hs = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// Negedge view equals what the next rising edge samples
		repeat (50) if (!hs) begin
			@(negedge core_clk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			hs = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge core_clk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (hs) s_axi_bready <= 1'b0;
		end
		// Idle edge so a following call never reassigns a handshake in this time step
		@(posedge core_clk);
		check("write answered", hs, 1'b1);
		check("write response", rsp, `AXI_OKAY);
	endtask : axiWrite
	task automatic axiRead(input logic [7:0] a);
		logic ar, hs;
		hs = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		repeat (50) if (!hs) begin
			@(negedge core_clk);
			ar = s_axi_arvalid && s_axi_arready;
			hs = s_axi_rvalid;
			rd = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge core_clk);
			if (ar) s_axi_arvalid <= 1'b0;
			if (hs) s_axi_rready <= 1'b0;
		end
		@(posedge core_clk);
		check("read answered", hs, 1'b1);
	endtask : axiRead
	// Bit-reflected CCITT, zero start, over the fetched octets
	function automatic logic [15:0] crcOf(input int n);
		logic [15:0] c;
		c = 16'h0000;
		for (int i = 0; i < n; i++) begin
			c = c ^ 16'(8'(i * 37 + 5));
			for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
		end
		return c;
	endfunction : crcOf
	task automatic checkFrame(input int base, input int len, input logic fcs);
		int nb;
		logic [15:0] c;
		nb = fcs ? len - 2 : len;
		c = crcOf(nb);
		check("octet count", u_tx_sink_model.rxCount - base, len);
		for (int i = 0; i < nb; i++) check("octet", u_tx_sink_model.rxBytes[base + i], 8'(i * 37 + 5));
		// Checksum goes out as the ones' complement of the running value, low byte first
		if (fcs) begin
			check("fcs low", u_tx_sink_model.rxBytes[base + nb], 8'(~c[7:0]));
			check("fcs high", u_tx_sink_model.rxBytes[base + nb + 1], 8'(~c[15:8]));
		end
	endtask : checkFrame
	task automatic waitFrame(input int n);
		repeat (3000) if (u_tx_sink_model.frames < n) @(posedge core_clk);
		check("frame ended", u_tx_sink_model.frames, n);
	endtask : waitFrame
	task automatic testRegs();
		axiRead(`SYSTEM_CONTROL_ADDR);
		check("control reset", rd, `SYSTEM_CONTROL_RESET);
		axiWrite(`SYSTEM_CONTROL_ADDR, 32'h01000380);
		axiRead(`SYSTEM_CONTROL_ADDR);
		check("stored bits", rd, 32'h01000380);
		axiWrite(`SYSTEM_CONTROL_ADDR, 32'h00000000);
		axiRead(8'h08);
		check("unmapped", rsp, `AXI_SLVERR);
		$display("test registers done");
	endtask : testRegs
	task automatic testSend(input logic [31:0] ctrl, input int len);
		int base, tgt;
		base = u_tx_sink_model.rxCount;
		tgt = u_tx_sink_model.frames + 1;
		axiWrite(`FRAME_LENGTH_ADDR, 32'(len));
		axiWrite(`SYSTEM_CONTROL_ADDR, ctrl);
		axiRead(`SYSTEM_CONTROL_ADDR);
		check("start cleared", rd, 32'h0);
		waitFrame(tgt);
		checkFrame(base, len, !ctrl[0]);
		$display("test send done");
	endtask : testSend
	task automatic testAbort();
		int tgt;
		tgt = u_tx_sink_model.frames;
		axiWrite(`DELAYED_TIME_HI_ADDR, 32'h000000FF);
		axiWrite(`SYSTEM_CONTROL_ADDR, 32'h00000006);
		axiRead(`TX_STATUS_ADDR);
		check("waiting busy", rd, 32'h1);
		axiWrite(`SYSTEM_CONTROL_ADDR, 32'h00000046);
		axiRead(`SYSTEM_CONTROL_ADDR);
		check("abort cleared", rd, 32'h0);
		axiRead(`TX_STATUS_ADDR);
		check("abort idle", rd, 32'h0);
		check("no frame", u_tx_sink_model.frames, tgt);
		$display("test abort done");
	endtask : testAbort
	task automatic testDelayed();
		int base, tgt;
		logic [31:0] at;
		base = u_tx_sink_model.rxCount;
		tgt = u_tx_sink_model.frames + 1;
		axiWrite(`FRAME_LENGTH_ADDR, 32'h6);
		axiWrite(`ANTENNA_DELAY_ADDR, 32'h00000123);
		axiRead(`SYSTEM_TIME_LO_ADDR);
		at = (rd + 32'h00000600) & 32'hFFFFFE00;
		axiWrite(`DELAYED_TIME_LO_ADDR, at | 32'h000001A5);
		axiWrite(`DELAYED_TIME_HI_ADDR, 32'h0);
		axiWrite(`SYSTEM_CONTROL_ADDR, 32'h00000006);
		axiRead(`SYSTEM_CONTROL_ADDR);
		check("delay pending", rd, 32'h6);
		check("no early send", u_tx_sink_model.rxCount, base);
		waitFrame(tgt);
		axiRead(`TX_STAMP_LO_ADDR);
		check("tx stamp", rd, at + 32'h123);
		axiRead(`SYSTEM_CONTROL_ADDR);
		check("delay cleared", rd, 32'h0);
		checkFrame(base, 6, 1'b1);
		$display("test delayed done");
	endtask : testDelayed
	initial begin
		repeat (20) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		testRegs();
		testSend(32'h2, 5);
		testSend(32'h3, 4);
		testAbort();
		testDelayed();
		final_report();
	end
	initial begin
		#(40 * 20000);
		n_errors++;
		final_report();
	end
endmodule : tx_command_control_tb
`default_nettype wire
